//--- rtb_map.svh
`ifndef RTB_MAP_SVH
`define RTB_MAP_SVH

// Address widths of the register port and the RAM ports
`define RTB_WORD_ADDR_W      15
`define RTB_BYTE_ADDR_W      17
`define RTB_RAM_ADDR_W       13

// Region bounds, byte addresses
`define RTB_PARAM_LAST       17'h000FF
`define RTB_STATUS_FIRST     17'h00100
`define RTB_STATUS_LAST      17'h002FF
`define RTB_CPARAM_FIRST     17'h00400
`define RTB_CPARAM_LAST      17'h004FF
`define RTB_CSTAT_FIRST      17'h00500
`define RTB_CSTAT_LAST       17'h005FF
`define RTB_VERSION_OFS      17'h00800
`define RTB_IDEN_FIRST       17'h10000
`define RTB_IDEN_LAST        17'h17FFF
`define RTB_CRAM_FIRST       17'h18000
`define RTB_CRAM_LAST        17'h1FFFF

// Parameter registers, low ten byte-address bits
`define RTB_START_LOW_OFS    10'h000
`define RTB_START_HIGH_OFS   10'h004
`define RTB_LENGTH_LOW_OFS   10'h008
`define RTB_LENGTH_HIGH_OFS  10'h00C
`define RTB_COMMAND_OFS      10'h010
`define RTB_PATTERN_OFS      10'h014
`define RTB_TIMEOUT_OFS      10'h020

// Status registers, low ten byte-address bits
`define RTB_ENGINE_STS_OFS   10'h100
`define RTB_CAP_LOW_OFS      10'h104
`define RTB_CAP_HIGH_OFS     10'h108
`define RTB_ERRTYPE0_OFS     10'h110
`define RTB_ERRTYPE1_OFS     10'h114
`define RTB_LINK0_OFS        10'h120
`define RTB_LINK1_OFS        10'h124
`define RTB_COMPSTS0_OFS     10'h130
`define RTB_COMPSTS1_OFS     10'h134
`define RTB_CAPAB0_OFS       10'h140
`define RTB_CAPAB1_OFS       10'h144
`define RTB_TESTPIN0_OFS     10'h150
`define RTB_TESTPIN1_OFS     10'h154
`define RTB_FAIL_LOW_OFS     10'h200
`define RTB_FAIL_HIGH_OFS    10'h204
`define RTB_TESTED_LOW_OFS   10'h208
`define RTB_TESTED_HIGH_OFS  10'h20C
`define RTB_EXPECTED_BASE    10'h280
`define RTB_ACTUAL_BASE      10'h2C0

// Custom submission block, byte-address bits 6:0 span both channels
`define RTB_SUBM_LAST        17'h0047F

// Reset value of every parameter register
`define RTB_PARAM_RESET      32'h00000000

// Read latency in clock cycles
`define RTB_READ_LATENCY     3

`endif

//--- rtb_pkg.sv
package rtb_pkg;

    // Hardware area selected by the upper address bits
    typedef enum logic [2:0] {
        AREA_NONE,
        AREA_PARAM,
        AREA_STATUS,
        AREA_CPARAM,
        AREA_CSTAT,
        AREA_VERSION,
        AREA_IDEN,
        AREA_CRAM
    } rtb_area_type;

    // Link state of one channel
    typedef struct packed {
        logic       linkup;
        logic [2:0] speed;
        logic [3:0] lane_width;
        logic [5:0] training_state;
    } rtb_link_type;

    // Status bundle of one storage controller channel
    typedef struct packed {
        logic [31:0]  controller_error_code;
        rtb_link_type link;
        logic [15:0]  admin_completion_status;
        logic [15:0]  io_completion_status;
        logic [31:0]  controller_capability;
        logic [31:0]  controller_debug_pins;
        logic [127:0] custom_completion_dwords;
    } rtb_channel_type;

    // Status of the striping engine and pattern checker
    typedef struct packed {
        logic         engine_busy;
        logic         engine_error;
        logic         verify_fail;
        logic         sector_size_mode;
        logic [47:0]  array_capacity;
        logic [56:0]  fail_address;
        logic [56:0]  tested_bytes;
        logic [255:0] expected_data;
        logic [255:0] actual_data;
        logic [31:0]  core_version;
    } rtb_engine_type;

    // Whole state of the bank
    typedef struct packed {
        logic [47:0]       start_sector;
        logic [47:0]       sector_count;
        logic [2:0]        command_code;
        logic              command_request;
        logic [2:0]        pattern_select;
        logic [31:0]       timeout_setting;
        logic [31:0][31:0] subm;
        logic [2:0]        valid_pipe;
        logic [31:0]       s1_data;
        rtb_area_type      s1_area;
        logic [31:0]       s2_data;
        rtb_area_type      s2_area;
        logic [31:0]       read_word;
        logic [12:0]       ram_addr;
        logic              cram_wr_en;
        logic [31:0]       cram_wr_data;
    } rtb_state_type;

endpackage

//--- rtb_test_register_bank.sv
`timescale 1ns/1ps
`include "rtb_map.svh"
module rtb_test_register_bank (
    input  wire logic                            clock_i,               // Logic clock, 25 MHz
    input  wire logic                            reset_n_i,             // Synchronous reset, active low
    input  wire logic [`RTB_WORD_ADDR_W-1:0]     word_address_i,        // Register address in words
    input  wire logic                            write_strobe_i,        // One-cycle write pulse
    input  wire logic [31:0]                     write_data_i,          // Write data
    input  wire logic [3:0]                      write_lane_enables_i,  // Byte lanes, not used
    input  wire logic                            read_request_i,        // One-cycle read pulse
    output logic                                 read_valid_o,          // Read data valid pulse
    output logic [31:0]                          read_word_o,           // Read data
    output logic [47:0]                          start_sector_o,        // Start address, 512-byte units
    output logic [47:0]                          sector_count_o,        // Transfer length, 512-byte units
    output logic [2:0]                           command_code_o,        // Engine command
    output logic                                 command_request_o,     // Command pulse
    output logic [2:0]                           pattern_select_o,      // Test pattern
    output logic [31:0]                          timeout_setting_o,     // Timeout for both controllers
    output logic [511:0]                         custom_submission_ch0_o, // Channel 0 entry, dword 0 low
    output logic [511:0]                         custom_submission_ch1_o, // Channel 1 entry, dword 0 low
    input  wire rtb_pkg::rtb_engine_type         engine_status_i,       // Engine and checker status
    input  wire rtb_pkg::rtb_channel_type [1:0]  channel_status_i,      // Per-channel status
    output logic [`RTB_RAM_ADDR_W-1:0]           iden_ram_addr_o,       // Identify RAM word address
    input  wire logic [31:0]                     iden_ram_data_i,       // Identify RAM data, 1-cycle
    output logic [`RTB_RAM_ADDR_W-1:0]           cram_addr_o,           // Custom RAM word address
    output logic                                 cram_wr_en_o,          // Custom RAM write enable
    output logic [31:0]                          cram_wr_data_o,        // Custom RAM write data
    input  wire logic [31:0]                     cram_rd_data_i         // Custom RAM data, 1-cycle
);
    import rtb_pkg::*;

    rtb_state_type                st;
    rtb_state_type                next_st;
    logic [`RTB_BYTE_ADDR_W-1:0]  byte_addr;
    rtb_area_type                 area;

    // Pick the hardware area from the upper address bits
    function automatic rtb_area_type area_of(input logic [`RTB_BYTE_ADDR_W-1:0] a);
        rtb_area_type r;
        r = AREA_NONE;
        if (a <= `RTB_PARAM_LAST) begin
            r = AREA_PARAM;
        end else if (a >= `RTB_STATUS_FIRST && a <= `RTB_STATUS_LAST) begin
            r = AREA_STATUS;
        end else if (a >= `RTB_CPARAM_FIRST && a <= `RTB_CPARAM_LAST) begin
            r = AREA_CPARAM;
        end else if (a >= `RTB_CSTAT_FIRST && a <= `RTB_CSTAT_LAST) begin
            r = AREA_CSTAT;
        end else if (a == `RTB_VERSION_OFS) begin
            r = AREA_VERSION;
        end else if (a >= `RTB_IDEN_FIRST && a <= `RTB_IDEN_LAST) begin
            r = AREA_IDEN;
        end else if (a >= `RTB_CRAM_FIRST && a <= `RTB_CRAM_LAST) begin
            r = AREA_CRAM;
        end
        return r;
    endfunction

    // Assemble one channel's link word
    function automatic logic [31:0] link_word(input rtb_link_type l);
        return {15'h0000, l.speed[2], 2'h0, l.training_state, l.lane_width, l.speed[1:0], 1'b0, l.linkup};
    endfunction

    // Byte address, bridge gives word units
    assign byte_addr = {word_address_i, 2'h0};
    assign area      = area_of(byte_addr);

    // Status area, first mux stage on the low address bits
    function automatic logic [31:0] status_word(input logic [9:0] ofs, input rtb_engine_type e,
                                                input rtb_channel_type [1:0] c);
        logic [31:0] w;
        w = 32'h00000000;
        if (ofs[9:5] == `RTB_EXPECTED_BASE >> 5) begin
            w = e.expected_data[ofs[4:2]*32 +: 32];
        end else if (ofs[9:5] == `RTB_ACTUAL_BASE >> 5) begin
            w = e.actual_data[ofs[4:2]*32 +: 32];
        end else begin
            case (ofs)
                `RTB_ENGINE_STS_OFS:  w = {29'h00000000, e.verify_fail, e.engine_error, e.engine_busy};
                `RTB_CAP_LOW_OFS:     w = e.array_capacity[31:0];
                `RTB_CAP_HIGH_OFS:    w = {e.sector_size_mode, 15'h0000, e.array_capacity[47:32]};
                `RTB_ERRTYPE0_OFS:    w = c[0].controller_error_code;
                `RTB_ERRTYPE1_OFS:    w = c[1].controller_error_code;
                `RTB_LINK0_OFS:       w = link_word(c[0].link);
                `RTB_LINK1_OFS:       w = link_word(c[1].link);
                `RTB_COMPSTS0_OFS:    w = {c[0].io_completion_status, c[0].admin_completion_status};
                `RTB_COMPSTS1_OFS:    w = {c[1].io_completion_status, c[1].admin_completion_status};
                `RTB_CAPAB0_OFS:      w = c[0].controller_capability;
                `RTB_CAPAB1_OFS:      w = c[1].controller_capability;
                `RTB_TESTPIN0_OFS:    w = c[0].controller_debug_pins;
                `RTB_TESTPIN1_OFS:    w = c[1].controller_debug_pins;
                `RTB_FAIL_LOW_OFS:    w = e.fail_address[31:0];
                `RTB_FAIL_HIGH_OFS:   w = {7'h00, e.fail_address[56:32]};
                `RTB_TESTED_LOW_OFS:  w = e.tested_bytes[31:0];
                `RTB_TESTED_HIGH_OFS: w = {7'h00, e.tested_bytes[56:32]};
                default:              w = 32'h00000000;
            endcase
        end
        return w;
    endfunction

    // Next-state logic: write decode and the three-stage read path
    always_comb begin
        next_st                 = st;
        next_st.command_request = 1'b0;
        next_st.cram_wr_en      = 1'b0;
        // Shared RAM address follows the bus every cycle; held by the bridge during reads
        next_st.ram_addr        = byte_addr[14:2];

        // Writes: full words only, byte lanes deliberately unused
        if (write_strobe_i) begin
            unique case (area)
                AREA_PARAM: begin
                    case (byte_addr[9:0])
                        `RTB_START_LOW_OFS:   next_st.start_sector[31:0]  = write_data_i;
                        `RTB_START_HIGH_OFS:  next_st.start_sector[47:32] = write_data_i[15:0];
                        `RTB_LENGTH_LOW_OFS:  next_st.sector_count[31:0]  = write_data_i;
                        `RTB_LENGTH_HIGH_OFS: next_st.sector_count[47:32] = write_data_i[15:0];
                        `RTB_COMMAND_OFS: begin
                            next_st.command_code    = write_data_i[2:0];
                            next_st.command_request = 1'b1;
                        end
                        `RTB_PATTERN_OFS:     next_st.pattern_select  = write_data_i[2:0];
                        `RTB_TIMEOUT_OFS:     next_st.timeout_setting = write_data_i;
                        default: ;
                    endcase
                end
                AREA_CPARAM: begin
                    // Beyond both submission blocks the area is a hole
                    if (byte_addr <= `RTB_SUBM_LAST) begin
                        next_st.subm[byte_addr[6:2]] = write_data_i;
                    end
                end
                AREA_CRAM: begin
                    next_st.cram_wr_en   = 1'b1;
                    next_st.cram_wr_data = write_data_i;
                end
                // Status, identify, version and holes absorb the write
                AREA_NONE, AREA_STATUS, AREA_CSTAT, AREA_VERSION, AREA_IDEN: ;
            endcase
        end

        // Read valid is the request through three flops
        next_st.valid_pipe = {st.valid_pipe[1:0], read_request_i};

        // Stage one: select within the area by the low address bits
        next_st.s1_area = area;
        unique case (area)
            AREA_STATUS:  next_st.s1_data = status_word(byte_addr[9:0], engine_status_i, channel_status_i);
            AREA_CSTAT: begin
                if (byte_addr[9:5] == 5'h08) begin
                    next_st.s1_data = channel_status_i[byte_addr[4]].custom_completion_dwords[byte_addr[3:2]*32 +: 32];
                end else begin
                    next_st.s1_data = 32'h00000000;
                end
            end
            AREA_VERSION: next_st.s1_data = engine_status_i.core_version;
            // Write-only areas and holes read as zero; RAM areas take their word in stage three
            AREA_NONE, AREA_PARAM, AREA_CPARAM, AREA_IDEN, AREA_CRAM:
                next_st.s1_data = 32'h00000000;
        endcase

        // Stage two: carry the area word while the RAMs answer
        next_st.s2_area = st.s1_area;
        next_st.s2_data = st.s1_data;

        // Stage three: area select, RAM data arrives in this cycle
        unique case (st.s2_area)
            AREA_IDEN:    next_st.read_word = iden_ram_data_i;
            AREA_CRAM:    next_st.read_word = cram_rd_data_i;
            AREA_NONE, AREA_PARAM, AREA_STATUS, AREA_CPARAM, AREA_CSTAT, AREA_VERSION:
                next_st.read_word = st.s2_data;
        endcase
    end

    // State register, synchronous reset to all zero
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign read_valid_o            = st.valid_pipe[2];
    assign read_word_o             = st.read_word;
    assign start_sector_o          = st.start_sector;
    assign sector_count_o          = st.sector_count;
    assign command_code_o          = st.command_code;
    assign command_request_o       = st.command_request;
    assign pattern_select_o        = st.pattern_select;
    assign timeout_setting_o       = st.timeout_setting;
    assign custom_submission_ch0_o = st.subm[15:0];
    assign custom_submission_ch1_o = st.subm[31:16];
    assign iden_ram_addr_o         = st.ram_addr;
    assign cram_addr_o             = st.ram_addr;
    assign cram_wr_en_o            = st.cram_wr_en;
    assign cram_wr_data_o          = st.cram_wr_data;

    // Checks, all on the one clock
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence seq_read_req;
        read_request_i;
    endsequence

    sequence seq_cmd_write;
        write_strobe_i && area == AREA_PARAM && byte_addr[9:0] == `RTB_COMMAND_OFS;
    endsequence

    sequence seq_ro_write;
        write_strobe_i && (area == AREA_STATUS || area == AREA_CSTAT || area == AREA_NONE);
    endsequence

    sequence seq_param_write;
        write_strobe_i && area == AREA_PARAM;
    endsequence

    sequence seq_subm_write;
        write_strobe_i && area == AREA_CPARAM && byte_addr <= `RTB_SUBM_LAST;
    endsequence

    sequence seq_iden_read;
        read_request_i && area == AREA_IDEN;
    endsequence

    sequence seq_cram_read;
        read_request_i && area == AREA_CRAM;
    endsequence

    chk_read_latency: assert property (seq_read_req |-> ##3 read_valid_o)
        else $error("read valid not three cycles after request");

    chk_valid_cause: assert property (read_valid_o |-> $past(read_request_i, 3))
        else $error("read valid without a request three cycles earlier");

    chk_cmd_pulse: assert property (seq_cmd_write |=> command_request_o && command_code_o == $past(write_data_i[2:0]))
        else $error("command write did not issue request with code");

    chk_cmd_cause: assert property (command_request_o |-> $past(write_strobe_i) && $past(byte_addr[9:0]) == `RTB_COMMAND_OFS)
        else $error("command request without command write");

    chk_ro_write_ignored: assert property (seq_ro_write |=>
                                           $stable(start_sector_o) && $stable(timeout_setting_o)
                                           && !command_request_o && !cram_wr_en_o)
        else $error("write to read-only or hole changed state");

    chk_param_read_zero: assert property (seq_read_req ##0 area == AREA_PARAM |-> ##3 read_valid_o && read_word_o == 32'h00000000)
        else $error("write-only area did not read zero");

    chk_status_bits: assert property (seq_read_req ##0 byte_addr == {7'h00, `RTB_ENGINE_STS_OFS} |=>
        st.s1_data[2:0] == $past({engine_status_i.verify_fail, engine_status_i.engine_error, engine_status_i.engine_busy}))
        else $error("status word bits misplaced");

    chk_timeout_load: assert property (seq_param_write ##0 byte_addr[9:0] == `RTB_TIMEOUT_OFS
                                       |=> timeout_setting_o == $past(write_data_i))
        else $error("timeout register not loaded");

    chk_start_high: assert property (seq_param_write ##0 byte_addr[9:0] == `RTB_START_HIGH_OFS
                                     |=> start_sector_o[47:32] == $past(write_data_i[15:0]))
        else $error("start sector high bits not loaded");

    chk_cram_write: assert property (write_strobe_i && area == AREA_CRAM |=> cram_wr_en_o
                                     && cram_wr_data_o == $past(write_data_i) && cram_addr_o == $past(byte_addr[14:2]))
        else $error("custom RAM write not forwarded");

    // Parameter loads; each write touches only its own field
    chk_start_low: assert property (seq_param_write ##0 byte_addr[9:0] == `RTB_START_LOW_OFS
                                    |=> start_sector_o[31:0] == $past(write_data_i))
        else $error("start sector low word not loaded");

    chk_length_low: assert property (seq_param_write ##0 byte_addr[9:0] == `RTB_LENGTH_LOW_OFS
                                     |=> sector_count_o[31:0] == $past(write_data_i))
        else $error("sector count low word not loaded");

    chk_length_high: assert property (seq_param_write ##0 byte_addr[9:0] == `RTB_LENGTH_HIGH_OFS
                                      |=> sector_count_o[47:32] == $past(write_data_i[15:0]))
        else $error("sector count high bits not loaded");

    chk_pattern_load: assert property (seq_param_write ##0 byte_addr[9:0] == `RTB_PATTERN_OFS
                                       |=> pattern_select_o == $past(write_data_i[2:0]))
        else $error("pattern select not loaded");

    // Submission dwords: one lands per write, any other write leaves the entry alone
    chk_subm_write: assert property (seq_subm_write |=>
                                     st.subm[$past(byte_addr[6:2])] == $past(write_data_i))
        else $error("submission dword not stored");

    chk_subm_stable: assert property (write_strobe_i
                                      && (area != AREA_CPARAM || byte_addr > `RTB_SUBM_LAST)
                                      |=> $stable(custom_submission_ch0_o) && $stable(custom_submission_ch1_o))
        else $error("submission entry changed by a foreign write");

    chk_cram_cause: assert property (cram_wr_en_o |-> $past(write_strobe_i) && $past(area) == AREA_CRAM)
        else $error("custom RAM write without a custom RAM address");

    // RAM reads: address goes out one cycle on, data is back in cycle three
    chk_iden_addr: assert property (seq_iden_read |=> iden_ram_addr_o == $past(byte_addr[14:2]))
        else $error("identify RAM address not forwarded");

    chk_iden_data: assert property (seq_iden_read |-> ##3 read_valid_o
                                    && read_word_o == $past(iden_ram_data_i))
        else $error("identify RAM data not returned");

    chk_cram_data: assert property (seq_cram_read |-> ##3 read_valid_o
                                    && read_word_o == $past(cram_rd_data_i))
        else $error("custom RAM data not returned");

    // A hole must not leak the word of an earlier read
    chk_hole_read_zero: assert property (seq_read_req ##0 area == AREA_NONE
                                         |-> ##3 read_word_o == 32'h00000000)
        else $error("unmapped address did not read zero");

endmodule

//--- rtb_bridge_model.sv
`timescale 1ns/1ps
module rtb_bridge_model (
    input  wire logic        clock_i,              // Logic clock
    output logic [14:0]      word_address_o,       // Word address
    output logic             write_strobe_o,       // Write pulse
    output logic [31:0]      write_data_o,         // Write data
    output logic [3:0]       write_lane_enables_o, // Byte lanes
    output logic             read_request_o,       // Read pulse
    input  wire logic        read_valid_i,         // Read valid
    input  wire logic [31:0] read_word_i           // Read data
);
    // Idle bus from time zero
    initial begin
        word_address_o = 15'h0000;
        write_strobe_o = 1'b0;
        write_data_o = 32'h0;
        write_lane_enables_o = 4'h0;
        read_request_o = 1'b0;
    end
    // Lanes left partial on purpose: the bank must still take the whole word
    task automatic reg_write(input logic [16:0] a, input logic [31:0] d);
        @(negedge clock_i);
        word_address_o = a[16:2];
        write_data_o = d;
        write_lane_enables_o = 4'h1;
        write_strobe_o = 1'b1;
        @(negedge clock_i);
        write_strobe_o = 1'b0;
        write_data_o = ~d; // Stale data must not be reused
    endtask
    // Address held until read valid, wait bounded
    task automatic reg_read(input logic [16:0] a, output logic [31:0] d, output int lat);
        @(negedge clock_i);
        word_address_o = a[16:2];
        read_request_o = 1'b1;
        @(negedge clock_i);
        read_request_o = 1'b0;
        lat = 1; // The request cycle itself is cycle zero
        while (read_valid_i !== 1'b1 && lat < 9) begin
            @(negedge clock_i);
            lat++;
        end
        d = read_word_i;
    endtask
endmodule

//--- rtb_test_register_bank_test.sv
`timescale 1ns/1ps
module rtb_test_register_bank_test;
    import rtb_pkg::*;
    typedef struct packed { logic [16:0] a; logic [31:0] e; } rtb_row_type;
    logic clock, reset_n, wr, rd, rv, creq, cwe;
    logic [14:0] waddr;
    logic [31:0] wd, rw, tmo, cwd, iden_d, cram_d, got;
    logic [3:0] lanes;
    logic [47:0] start, count;
    logic [2:0] code, patt;
    logic [511:0] sub0, sub1;
    logic [12:0] iaddr, caddr;
    logic [31:0] cram [8192];
    rtb_engine_type eng;
    rtb_channel_type [1:0] ch;
    rtb_row_type rows [23];
    int fail_count, n_compared, lat;
    rtb_bridge_model bridge (.clock_i(clock), .word_address_o(waddr), .write_strobe_o(wr), .write_data_o(wd),
        .write_lane_enables_o(lanes), .read_request_o(rd), .read_valid_i(rv), .read_word_i(rw));
    rtb_test_register_bank dut (.clock_i(clock), .reset_n_i(reset_n), .word_address_i(waddr), .write_strobe_i(wr),
        .write_data_i(wd), .write_lane_enables_i(lanes), .read_request_i(rd), .read_valid_o(rv), .read_word_o(rw),
        .start_sector_o(start), .sector_count_o(count), .command_code_o(code), .command_request_o(creq),
        .pattern_select_o(patt), .timeout_setting_o(tmo), .custom_submission_ch0_o(sub0),
        .custom_submission_ch1_o(sub1), .engine_status_i(eng), .channel_status_i(ch), .iden_ram_addr_o(iaddr),
        .iden_ram_data_i(iden_d), .cram_addr_o(caddr), .cram_wr_en_o(cwe), .cram_wr_data_o(cwd),
        .cram_rd_data_i(cram_d));
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Clock at 25 MHz
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // RAMs answer one cycle after the address, updated off the sampling edge
    always @(negedge clock) begin
        iden_d <= {16'h1DE0, 3'h0, iaddr};
        if (cwe === 1'b1) cram[caddr] <= cwd;
        cram_d <= cram[caddr];
    end
    // Hang guard, far beyond the fewer than two hundred cycles the tests need
    initial begin
        #(40 * 5000);
        fail_count++;
        end_of_test();
    end
    initial begin
        reset_n = 1'b0;
        {iden_d, cram_d, eng, ch} = '0;
        {eng.engine_busy, eng.verify_fail, eng.sector_size_mode} = 3'h7;
        eng.array_capacity = 48'h123489ABCDEF;
        eng.fail_address = 57'h1FFFFFF00000001;
        eng.tested_bytes = 57'h0ABCDEF12345678;
        eng.core_version = 32'h01020304;
        for (int k = 0; k < 8; k++) begin
            eng.expected_data[32*k +: 32] = 32'hE0000000 + k;
            eng.actual_data[32*k +: 32] = 32'hA0000000 + k;
        end
        for (int c = 0; c < 2; c++) begin
            ch[c].controller_error_code = 32'hC0DE0000 + c;
            ch[c].link = '{1'b1, c ? 3'h3 : 3'h7, 4'h4, 6'h2A};
            {ch[c].io_completion_status, ch[c].admin_completion_status} = 32'h10C0AD00;
            for (int k = 0; k < 4; k++) ch[c].custom_completion_dwords[32*k +: 32] = 32'hCC000000 + 16*c + k;
        end
        rows = '{'{17'h100, 32'h5}, '{17'h104, 32'h89ABCDEF}, '{17'h108, 32'h80001234}, '{17'h110, 32'hC0DE0000},
            '{17'h114, 32'hC0DE0001}, '{17'h120, 32'h12A4D}, '{17'h124, 32'h2A4D}, '{17'h130, 32'h10C0AD00},
            '{17'h200, 32'h1}, '{17'h204, 32'h1FFFFFF}, '{17'h208, 32'h12345678}, '{17'h20C, 32'hABCDEF},
            '{17'h280, 32'hE0000000}, '{17'h29C, 32'hE0000007}, '{17'h2C4, 32'hA0000001}, '{17'h50C, 32'hCC000003},
            '{17'h510, 32'hCC000010}, '{17'h800, 32'h1020304}, '{17'h0, 32'h0}, '{17'h400, 32'h0},
            '{17'h300, 32'h0}, '{17'h11004, 32'h1DE00401}, '{17'h13FFC, 32'h1DE00FFF}};
        repeat (20) @(posedge clock);
        @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        check({start, code, creq, cwe}, 64'h0);
        foreach (rows[i]) begin
            bridge.reg_read(rows[i].a, got, lat);
            check(got, rows[i].e);
            check(lat, 3);
        end
        bridge.reg_write(17'h0, 32'hDEADBEEF);
        bridge.reg_write(17'h4, 32'hFFFF1234);
        bridge.reg_write(17'h8, 32'h1);
        bridge.reg_write(17'hC, 32'h0000FFFF);
        bridge.reg_write(17'h20, 32'hFFFFFFFE);
        bridge.reg_write(17'h400, 32'h5AB00000);
        bridge.reg_write(17'h47C, 32'h5AB1000F);
        check(start, 48'h1234DEADBEEF);
        check({count, tmo[15:0]}, 64'hFFFF00000001FFFE);
        check({sub0[31:0], sub1[511:480]}, 64'h5AB000005AB1000F);
        // Writes into read-only, ignored and unmapped places
        bridge.reg_write(17'h480, 32'h0);
        bridge.reg_write(17'h100, 32'h0);
        bridge.reg_write(17'hFC, 32'h0);
        bridge.reg_write(17'h10000, 32'h0);
        check(cwe, 0);
        check({sub0[31:0], start[31:0]}, 64'h5AB00000DEADBEEF);
        check({tmo, count[31:0]}, 64'hFFFFFFFE00000001);
        for (int k = 0; k < 8; k++) begin
            bridge.reg_write(17'h10, 32'hFFFFFFF8 | k);
            check({creq, code}, {1'b1, 3'(k)});
            @(negedge clock);
            check(creq, 0);
            if (k < 5) bridge.reg_write(17'h14, k);
            if (k < 5) check(patt, k);
        end
        bridge.reg_write(17'h1A004, 32'h600DF00D);
        check({cwe, caddr, cwd}, {1'b1, 13'h0801, 32'h600DF00D});
        bridge.reg_read(17'h1A004, got, lat);
        check(got, 32'h600DF00D);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        check({start, tmo[15:0]}, 64'h0);
        end_of_test();
    end
endmodule
